// ===== rtl/ahp_pkg.sv
// shared constants and types of the converter host bus port
package ahp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 5;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned INT_SRC_N = 8;
    localparam int unsigned FCNT_W    = 6;

    // ------------------------------------------------------------
    // address map of the five address lines
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RAM_FIRST_ADDR  = 5'h00;
    localparam logic [ADDR_W-1:0] RAM_LAST_ADDR   = 5'h0F;
    localparam logic [ADDR_W-1:0] REG_FIRST_ADDR  = 5'h10;
    localparam logic [ADDR_W-1:0] REG_LAST_ADDR   = 5'h1E;
    localparam logic [ADDR_W-1:0] FIFO_ADDR       = 5'h1F;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 5'h13;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic                 INT_N_RST    = 1'b1;
    localparam logic                 XFER_REQ_RST = 1'b0;
    localparam logic [ADDR_W-1:0]    ADDR_RST     = 5'h00;
    localparam logic                 CS_N_RST     = 1'b1;
    localparam logic [DATA_W-1:0]    DATA_RST     = 16'h0000;
    localparam logic [INT_SRC_N-1:0] PEND_RST     = 8'h00;

    // byte enables for the two bus widths
    localparam logic [1:0] BE_NARROW = 2'b01;
    localparam logic [1:0] BE_WIDE   = 2'b11;

    typedef enum logic [1:0] {
        AHP_TGT_RAM,
        AHP_TGT_REG,
        AHP_TGT_FIFO
    } ahp_target_e;

    typedef enum {
        AHP_IDLE,
        AHP_READ,
        AHP_WRITE
    } ahp_state_e;

endpackage

// ===== rtl/ahp_addr_latch.sv
// address latch for multiplexed or direct host buses
`timescale 1ns/1ps
module ahp_addr_latch
    import ahp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              ale,
    input  wire logic [ADDR_W-1:0] address_lines,
    input  wire logic              cs_n,
    output logic      [ADDR_W-1:0] eff_addr,
    output logic                   eff_cs_n
);

    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic              cs_n_q;
    logic              cs_n_d;

    // ------------------------------------------------------------
    // latch state
    // ------------------------------------------------------------
    always_comb begin
        addr_d = addr_q;
        cs_n_d = cs_n_q;
        // the last value seen while the strobe is high is what the falling edge keeps
        if (ale) begin
            addr_d = address_lines;
            cs_n_d = cs_n;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= ADDR_RST;
            cs_n_q <= CS_N_RST;
        end else if (clk_en) begin
            addr_q <= addr_d;
            cs_n_q <= cs_n_d;
        end
    end

    // transparent while the strobe is high, frozen while it is low
    assign eff_addr = ale ? address_lines : addr_q;
    assign eff_cs_n = ale ? cs_n : cs_n_q;

endmodule

// ===== rtl/ahp_port.sv
// host bus port: strobes, data lane steering, interrupt and transfer request
`timescale 1ns/1ps
// What this block does
// - Width select high: upper eight data lines floated, lower eight carry data.
// - Width select low: all sixteen data lines carry data.
// - Data drivers enabled only while read strobe and select are both low.
// - Bus data accepted into addressed location while write strobe and select low.
// - Select low halts internal clocking and conversion; select high resumes.
// - Latch strobe high makes the address lines a valid address.
// - Falling latch strobe with select low captures the five address lines.
// - Latch strobe low: address line and select changes are ignored.
// - Five address lines decode into registers, result FIFO or instruction RAM.
// - A falling read strobe returns the interrupt output high unless a source fires in the same cycle.
// - Unmasked source of eight asserts interrupt; status register read clears it.
// - Transfer request rises at count equal threshold, drops when FIFO empty.
module ahp_port
    import ahp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 bus_width_select,
    input  wire logic                 rd_n,
    input  wire logic                 wr_n,
    input  wire logic                 cs_n,
    input  wire logic                 ale,
    input  wire logic [ADDR_W-1:0]    address_lines,
    input  wire logic [DATA_W-1:0]    data_lines_in,
    output logic      [DATA_W-1:0]    data_lines_out,
    output logic      [DATA_W-1:0]    data_lines_oe,
    output logic                      int_n,
    output logic                      transfer_request,
    output logic                      conv_halt,
    output logic                      rd_strobe,
    output logic                      wr_strobe,
    output logic      [ADDR_W-1:0]    acc_addr,
    output ahp_target_e               acc_target,
    output logic      [DATA_W-1:0]    wr_data,
    output logic      [1:0]           wr_be,
    input  wire logic [DATA_W-1:0]    rd_data,
    input  wire logic [INT_SRC_N-1:0] int_event,
    input  wire logic [INT_SRC_N-1:0] int_mask,
    input  wire logic [FCNT_W-1:0]    fifo_count,
    input  wire logic [FCNT_W-1:0]    xfer_threshold,
    input  wire logic                 fifo_empty
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic ahp_target_e decode_target(input logic [ADDR_W-1:0] a);
        if (a == FIFO_ADDR) begin
            decode_target = AHP_TGT_FIFO;
        end else if (a >= REG_FIRST_ADDR) begin
            decode_target = AHP_TGT_REG;
        end else begin
            decode_target = AHP_TGT_RAM;
        end
    endfunction

    logic [ADDR_W-1:0] eff_addr;
    logic              eff_cs_n;

    ahp_addr_latch u_latch (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .ale           (ale),
        .address_lines (address_lines),
        .cs_n          (cs_n),
        .eff_addr      (eff_addr),
        .eff_cs_n      (eff_cs_n)
    );

    logic rd_act;
    logic wr_act;
    assign rd_act    = !rd_n && !eff_cs_n;
    assign wr_act    = !wr_n && !eff_cs_n;
    // the converter clock stops for the whole select window; the access sequencer keeps running
    assign conv_halt = !eff_cs_n;

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    ahp_state_e        state_q;
    ahp_state_e        state_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [1:0]        be_q;
    logic [1:0]        be_d;
    logic              rd_start;
    logic              wr_done;

    always_comb begin
        state_d  = state_q;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        rdata_d  = rdata_q;
        be_d     = be_q;
        rd_start = 1'b0;
        wr_done  = 1'b0;
        case (state_q)
            AHP_IDLE: begin
                if (rd_act) begin
                    state_d  = AHP_READ;
                    addr_d   = eff_addr;
                    rd_start = 1'b1;
                end else if (wr_act) begin
                    state_d = AHP_WRITE;
                    addr_d  = eff_addr;
                    wdata_d = data_lines_in;
                    be_d    = bus_width_select ? BE_NARROW : BE_WIDE;
                end
            end
            AHP_READ: begin
                rdata_d = rd_data;
                if (!rd_act) begin
                    state_d = AHP_IDLE;
                end
            end
            AHP_WRITE: begin
                // data is taken on the last low cycle, matching setup to the rising strobe
                if (wr_act) begin
                    wdata_d = data_lines_in;
                    be_d    = bus_width_select ? BE_NARROW : BE_WIDE;
                end else begin
                    state_d = AHP_IDLE;
                    wr_done = 1'b1;
                end
            end
            default: begin
                state_d = AHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AHP_IDLE;
            addr_q  <= ADDR_RST;
            wdata_q <= DATA_RST;
            rdata_q <= DATA_RST;
            be_q    <= BE_WIDE;
        end else if (clk_en) begin
            state_q <= state_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            be_q    <= be_d;
        end
    end

    assign rd_strobe  = rd_start && clk_en;
    assign wr_strobe  = wr_done && clk_en;
    assign acc_addr   = addr_q;
    assign acc_target = decode_target(addr_q);
    assign wr_data    = wdata_q;
    assign wr_be      = be_q;

    // ------------------------------------------------------------
    // data lane drivers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_lane
            if (gi < BYTE_W) begin : g_low
                assign data_lines_oe[gi] = rd_act;
            end else begin : g_high
                assign data_lines_oe[gi] = rd_act && !bus_width_select;
            end
        end
    endgenerate
    // narrow mode hands out the low byte of the addressed word
    assign data_lines_out = rdata_q;

    // ------------------------------------------------------------
    // interrupt and transfer request
    // ------------------------------------------------------------
    logic [INT_SRC_N-1:0] pend_q;
    logic [INT_SRC_N-1:0] pend_d;
    logic                 int_n_q;
    logic                 int_n_d;
    logic                 xreq_q;
    logic                 xreq_d;
    logic [INT_SRC_N-1:0] new_int;
    logic                 stat_rd;

    always_comb begin
        new_int = int_event & ~int_mask;
        stat_rd = rd_start && (eff_addr == INT_STATUS_ADDR);
        pend_d  = pend_q;
        if (stat_rd) begin
            pend_d = PEND_RST;
        end
        pend_d  = pend_d | new_int;
        int_n_d = int_n_q;
        // a source firing in the same cycle as the release keeps the line low
        if (|new_int) begin
            int_n_d = 1'b0;
        end else if (rd_start) begin
            int_n_d = 1'b1;
        end
        xreq_d = xreq_q;
        if (fifo_count == xfer_threshold && !fifo_empty) begin
            xreq_d = 1'b1;
        end else if (fifo_empty) begin
            xreq_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q  <= PEND_RST;
            int_n_q <= INT_N_RST;
            xreq_q  <= XFER_REQ_RST;
        end else if (clk_en) begin
            pend_q  <= pend_d;
            int_n_q <= int_n_d;
            xreq_q  <= xreq_d;
        end
    end

    assign int_n            = int_n_q;
    assign transfer_request = xreq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_high_lane_float: assert property (
        bus_width_select |-> data_lines_oe[DATA_W-1:BYTE_W] == 8'h00)
        else $error("upper data lanes driven in narrow mode");
    chk_wide_lane_drive: assert property (
        (!bus_width_select && rd_act) |-> &data_lines_oe)
        else $error("wide read does not drive all lanes");
    chk_drive_needs_rd: assert property (
        data_lines_oe[0] |-> (!rd_n && !eff_cs_n))
        else $error("data driven outside read window");
    chk_write_pulse: assert property (
        (clk_en && state_q == AHP_WRITE && wr_act) ##1 (clk_en && !wr_act) |-> wr_strobe)
        else $error("write not accepted at strobe end");
    chk_halt_follow: assert property (
        ale |-> conv_halt == !cs_n)
        else $error("halt does not track select");
    chk_latch_hold: assert property (
        (!ale && $past(!ale) && clk_en) |=> $stable(eff_addr) || ale)
        else $error("latched address moved while strobe low");
    chk_latch_capture: assert property (
        (clk_en && ale && !cs_n) ##1 !ale |-> eff_addr == $past(address_lines))
        else $error("address not captured on falling latch strobe");
    chk_int_release: assert property (
        (rd_strobe && !(|new_int)) |=> int_n)
        else $error("interrupt not released after read");
    chk_int_assert: assert property (
        (clk_en && |new_int) |=> !int_n ##0 pend_q != PEND_RST)
        else $error("unmasked source did not assert interrupt");
    chk_xreq_drop: assert property (
        (clk_en && fifo_empty) |=> !transfer_request)
        else $error("transfer request held with empty fifo");
    chk_latch_pass: assert property (
        ale |-> eff_addr == address_lines)
        else $error("latch not transparent while strobe high");

    cov_read_narrow:  cover property (rd_strobe && bus_width_select);
    cov_write_wide:   cover property (wr_strobe && wr_be == BE_WIDE);
    cov_int_cycle:    cover property (!int_n ##[1:20] int_n);
    cov_xreq_cycle:   cover property (transfer_request ##[1:50] !transfer_request);

endmodule

// ===== verif/ahp_host_model.sv
// host bus controller model driving the converter port strobes
`timescale 1ns/1ps
module ahp_host_model
    import ahp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [DATA_W-1:0] data_lines_out,
    input  wire logic [DATA_W-1:0] data_lines_oe,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   cs_n,
    output logic                   ale,
    output logic      [ADDR_W-1:0] address_lines,
    output logic      [DATA_W-1:0] data_lines_in
);
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        ale = 1'b1;
        address_lines = 5'h00;
        data_lines_in = 16'h0000;
    end

    // select goes low only around the access, so conversion stalls briefly
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                          output logic [DATA_W-1:0] oe);
        @(posedge mclk);
        #1;
        cs_n = 1'b0;
        address_lines = a;
        data_lines_in = wd;
        if (wr) begin
            wr_n = 1'b0;
        end else begin
            rd_n = 1'b0;
        end
        repeat (4) @(posedge mclk);
        oe = data_lines_oe;
        // undriven lanes read back inverted so a missing enable cannot hide
        rd = (data_lines_out & data_lines_oe) | (~data_lines_out & ~data_lines_oe);
        #1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        ale = 1'b1;
        @(posedge mclk);
        #1;
        // a released bus must not keep showing the old word
        data_lines_in = ~wd;
        address_lines = ~a;
    endtask

    task automatic latch_addr(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        #1;
        cs_n = 1'b0;
        address_lines = a;
        @(posedge mclk);
        #1;
        ale = 1'b0;
        @(posedge mclk);
        #1;
        cs_n = 1'b1;
        address_lines = ~a;
    endtask
endmodule

// ===== verif/adc_host_bus_port_test.sv
// self-checking bench of the converter host bus port
`timescale 1ns/1ps
module adc_host_bus_port_test
    import ahp_pkg::*;
;
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 bus_width_select = 1'b0;
    logic                 clk_en = 1'b1;
    logic [INT_SRC_N-1:0] int_event = 8'h00;
    logic [INT_SRC_N-1:0] int_mask = 8'h00;
    logic [FCNT_W-1:0]    fifo_count = 6'h00;
    logic [FCNT_W-1:0]    xfer_threshold = 6'h04;
    logic                 fifo_empty = 1'b1;
    logic                 rd_n, wr_n, cs_n, ale, int_n, transfer_request;
    logic                 conv_halt, rd_strobe, wr_strobe;
    logic [ADDR_W-1:0]    address_lines, acc_addr;
    logic [DATA_W-1:0]    data_lines_in, data_lines_out, data_lines_oe;
    logic [DATA_W-1:0]    wr_data, rd_data, got, oe, last_wd;
    logic [1:0]           wr_be, last_be;
    ahp_target_e          acc_target;
    int                   n_errors = 0;
    int                   samples_checked = 0;
    int                   n_wr = 0;
    int                   n_rd = 0;

    always #2.5 mclk = ~mclk;

    // core word is a pattern of its own address so a wrong decode shows
    function automatic logic [DATA_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        return {a, 3'h5, ~a, 3'h2};
    endfunction
    assign rd_data = word_of(acc_addr);

    ahp_port dut (
        .mclk, .rst_n, .clk_en, .bus_width_select, .rd_n, .wr_n, .cs_n, .ale,
        .address_lines, .data_lines_in, .data_lines_out, .data_lines_oe, .int_n,
        .transfer_request, .conv_halt, .rd_strobe, .wr_strobe, .acc_addr, .acc_target,
        .wr_data, .wr_be, .rd_data, .int_event, .int_mask, .fifo_count,
        .xfer_threshold, .fifo_empty
    );

    ahp_host_model host (
        .mclk, .data_lines_out, .data_lines_oe, .rd_n, .wr_n, .cs_n, .ale,
        .address_lines, .data_lines_in
    );

    always @(posedge mclk) begin
        if (rd_strobe === 1'b1) begin
            n_rd <= n_rd + 1;
        end
        if (wr_strobe === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wd <= wr_data;
            last_be <= wr_be;
        end
    end

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        check("int_n", 16'h0001, 16'(int_n));
        check("xfer", 16'h0000, 16'(transfer_request));
        check("oe idle", 16'h0000, data_lines_oe);
        $display("test reset done");
    endtask

    task automatic test_reads();
        bus_width_select = 1'b0;
        host.access(1'b0, 5'h05, 16'h0000, got, oe);
        check("oe wide", 16'hFFFF, oe);
        check("word wide", word_of(5'h05), got);
        check("rd count wide", 16'h0001, 16'(n_rd));
        check("target ram", 16'(AHP_TGT_RAM), 16'(acc_target));
        check("oe released", 16'h0000, data_lines_oe);
        bus_width_select = 1'b1;
        host.access(1'b0, 5'h1F, 16'h0000, got, oe);
        check("oe narrow", 16'h00FF, oe);
        check("low byte", 16'(word_of(5'h1F) & 16'h00FF), got & 16'h00FF);
        check("target fifo", 16'(AHP_TGT_FIFO), 16'(acc_target));
        check("rd count narrow", 16'h0002, 16'(n_rd));
        $display("test reads done");
    endtask

    task automatic test_writes();
        bus_width_select = 1'b0;
        host.access(1'b1, 5'h10, 16'hA55A, got, oe);
        check("wide wr count", 16'h0001, 16'(n_wr));
        check("wide wr data", 16'hA55A, last_wd);
        check("wide wr be", 16'(BE_WIDE), 16'(last_be));
        check("target reg", 16'(AHP_TGT_REG), 16'(acc_target));
        check("oe on write", 16'h0000, oe);
        bus_width_select = 1'b1;
        host.access(1'b1, 5'h02, 16'h003C, got, oe);
        check("narrow wr count", 16'h0002, 16'(n_wr));
        check("narrow wr data", 16'h003C, last_wd & 16'h00FF);
        check("narrow wr be", 16'(BE_NARROW), 16'(last_be));
        check("no rd on write", 16'h0002, 16'(n_rd));
        $display("test writes done");
    endtask

    task automatic test_latch();
        bus_width_select = 1'b0;
        check("halt idle", 16'h0000, 16'(conv_halt));
        host.latch_addr(5'h0C);
        check("halt latched", 16'h0001, 16'(conv_halt));
        host.access(1'b0, 5'h1F, 16'h0000, got, oe);
        check("latched addr", 16'h000C, 16'(acc_addr));
        check("latched word", word_of(5'h0C), got);
        check("halt resumed", 16'h0000, 16'(conv_halt));
        $display("test latch done");
    endtask

    task automatic pulse_event(input logic [INT_SRC_N-1:0] e);
        step(1);
        int_event = e;
        step(1);
        int_event = 8'h00;
        step(1);
    endtask

    task automatic test_int();
        int_mask = 8'hFE;
        pulse_event(8'h02);
        check("masked int_n", 16'h0001, 16'(int_n));
        pulse_event(8'h01);
        check("int_n set", 16'h0000, 16'(int_n));
        host.access(1'b0, INT_STATUS_ADDR, 16'h0000, got, oe);
        check("int_n released", 16'h0001, 16'(int_n));
        $display("test interrupt done");
    endtask

    task automatic test_xfer();
        fifo_empty = 1'b0;
        fifo_count = 6'h03;
        step(2);
        check("xfer below", 16'h0000, 16'(transfer_request));
        fifo_count = 6'h04;
        step(1);
        check("xfer equal", 16'h0001, 16'(transfer_request));
        fifo_count = 6'h05;
        step(1);
        check("xfer held", 16'h0001, 16'(transfer_request));
        fifo_empty = 1'b1;
        fifo_count = 6'h00;
        step(1);
        check("xfer empty", 16'h0000, 16'(transfer_request));
        $display("test transfer request done");
    endtask

    // a source firing while the enable is low must leave no trace
    task automatic test_freeze();
        clk_en = 1'b0;
        pulse_event(8'h01);
        check("int_n frozen", 16'h0001, 16'(int_n));
        clk_en = 1'b1;
        pulse_event(8'h01);
        check("int_n thawed", 16'h0000, 16'(int_n));
        $display("test clock enable done");
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        $display("CHECK FAILED watchdog expected done seen hang");
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        test_reset();
        test_reads();
        test_writes();
        test_latch();
        test_int();
        test_xfer();
        test_freeze();
        complete_run();
    end
endmodule
